//--- rtl/smlm_pkg.sv
// Shared constants and types of the serial memory lane mapper.
// Assumes a 50 MHz system clock; every user sits on that clock.
package smlm_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int unsigned NUM_DEV = 4;
    localparam int unsigned LANES = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned CNT_W = 8;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned SCK_PERIOD_NS = 160;
    // Least half period, rounded up to whole cycles
    localparam int unsigned SCK_HALF_CYC =
        ((SCK_PERIOD_NS / 2) + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CS_GAP_NS = 40;
    localparam int unsigned CS_GAP_CYC =
        (CS_GAP_NS + CLK_NS - 1) / CLK_NS;

    // ************************************************************
    // Lane groups and reset values
    // ************************************************************
    localparam logic [1:0] GRP_LOW = 2'h0;
    localparam logic [1:0] GRP_HIGH = 2'h2;
    localparam logic [7:0] LANE_RST = 8'h00;
    localparam logic [3:0] SEL_IDLE = 4'hf;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SMLM_W1,
        SMLM_W2,
        SMLM_W4,
        SMLM_W8
    } smlm_width_t;

    // One byte of a frame; the selects follow dev and dq of the first item only
    typedef struct packed {
        logic [1:0] dev;
        logic dq;
        logic rx;
        smlm_width_t width;
        logic last;
        logic [7:0] data;
    } smlm_item_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } smlm_lanes_t;

    localparam int unsigned ITEM_W = $bits(smlm_item_t);

endpackage : smlm_pkg

//--- rtl/smlm_sync.sv
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ns
module smlm_sync #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } smlm_sync_state_t;

    smlm_sync_state_t s_q;
    smlm_sync_state_t s_d;

    // The first stage feeds only the second one
    always_comb begin
        s_d = s_q;
        s_d.meta = async_i;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.stable;

endmodule : smlm_sync

//--- rtl/smlm_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/1ns
module smlm_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO depth must be a power of two, two or more");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } smlm_fifo_state_t;

    smlm_fifo_state_t s_q;
    smlm_fifo_state_t s_d;
    logic push;
    logic pop;

    always_comb begin
        s_d = s_q;
        push = in_valid && s_q.rdy;
        pop = (s_q.cnt != '0) && out_ready;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = AW'(s_q.wp + 1'b1);
        end
        if (pop) begin
            s_d.rp = AW'(s_q.rp + 1'b1);
        end
        s_d.cnt = (AW + 1)'(s_q.cnt + {AW'(0), push} - {AW'(0), pop});
        // Registered ready: full is honest one cycle ahead
        s_d.rdy = (s_d.cnt < (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready = s_q.rdy;
    assign out_valid = (s_q.cnt != '0);
    assign out_data = s_q.mem[s_q.rp];

endmodule : smlm_fifo

//--- rtl/smlm_top.sv
// Lane mapper and bit serialiser of a serial memory interface master.
// Assumes the transfer engine sends frames as a stream of byte items
// and the memories are SPI mode 0 parts on up to four selects.
//
// Operation
// [R1] Every byte travels bit 7 first
// [R2] Single: SI lower lane out, SO upper in
// [R3] Dual: two bits per cycle, high on upper
// [R4] Quad: upper nibble, then lower nibble
// [R5] Octal: whole byte per cycle, bit 7 top
// [R6] Lane group placeable; only that group used
// [R7] One select per access on shared lanes
// [R8] Dual-quad uses two separate quad groups
// [R9] Dual-quad asserts both selects together
// [R10] Lower index low group, higher index high
// [R11] Dual-quad command bytes: same nibble both
// [R12] Dual-quad data: one octal cycle per byte
// [R13] Two-bit group code; quad, octal restricted
// [R14] Four fixed active-low selects, one per device
// [R15] Clock idles low, launch on falling edge
// [R16] Release lane drivers during wide reads
`timescale 1ns/1ns
module smlm_top #(
    parameter int unsigned FIFO_DEPTH = smlm_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Byte items from the transfer engine
    input wire smlm_pkg::smlm_item_t item_data,
    input wire logic item_valid,
    output logic item_ready,
    // Static device configuration
    input wire logic [2*smlm_pkg::NUM_DEV-1:0] dev_grp,
    input wire logic [1:0] dq_partner,
    // Received bytes
    output logic [7:0] rx_byte,
    output logic rx_valid,
    // Status
    output logic busy,
    output logic cfg_err,
    // Memory pins
    output logic sck,
    output logic [smlm_pkg::NUM_DEV-1:0] sel_n,
    input wire logic [smlm_pkg::LANES-1:0] lane_i,
    output logic [smlm_pkg::LANES-1:0] lane_o,
    output logic [smlm_pkg::LANES-1:0] lane_oe
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (smlm_pkg::SCK_HALF_CYC < 3) begin : g_bad_half
        $error("SCK half period too short for the input synchroniser");
    end
    if (smlm_pkg::NUM_DEV != 4) begin : g_bad_dev
        $error("Select logic is built for four devices");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_WAIT,
        ST_GAP
    } smlm_state_t;

    typedef struct packed {
        smlm_state_t st;
        logic [smlm_pkg::CNT_W-1:0] div;
        logic [2:0] left;
        logic sck;
        logic [3:0] sel_n;
        logic [7:0] sh;
        smlm_pkg::smlm_width_t width;
        logic rx;
        logic last;
        logic dq;
        logic [1:0] grp;
        logic [1:0] dev;
        smlm_pkg::smlm_lanes_t lanes;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic busy;
        logic err;
    } smlm_top_state_t;

    localparam logic [smlm_pkg::CNT_W-1:0] HALF_LAST =
        smlm_pkg::CNT_W'(smlm_pkg::SCK_HALF_CYC - 1);
    localparam logic [smlm_pkg::CNT_W-1:0] GAP_LAST =
        smlm_pkg::CNT_W'(smlm_pkg::CS_GAP_CYC - 1);

    smlm_top_state_t s_q;
    smlm_top_state_t s_d;

    // ************************************************************
    // Input path: item FIFO and pin synchroniser
    // ************************************************************
    smlm_pkg::smlm_item_t q_item;
    logic q_valid;
    logic q_pop;
    logic [7:0] lane_s;

    smlm_fifo #(
        .W(smlm_pkg::ITEM_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(item_data),
        .in_valid(item_valid),
        .in_ready(item_ready),
        .out_data(q_item),
        .out_valid(q_valid),
        .out_ready(q_pop)
    );

    smlm_sync #(
        .W(smlm_pkg::LANES)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_i(lane_i),
        .sync_o(lane_s)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    // Shifts per byte, less one
    function automatic logic [2:0] first_left(
        input smlm_pkg::smlm_width_t w
    );
        case (w)
            smlm_pkg::SMLM_W1: first_left = 3'h7;
            smlm_pkg::SMLM_W2: first_left = 3'h3;
            smlm_pkg::SMLM_W4: first_left = 3'h1;
            default: first_left = 3'h0;
        endcase
    endfunction : first_left

    // Group actually used; wide devices only sit where legal
    function automatic logic [1:0] eff_grp(
        input smlm_pkg::smlm_width_t w,
        input logic [1:0] g,
        input logic dq
    );
        if (dq || w == smlm_pkg::SMLM_W8) begin
            eff_grp = smlm_pkg::GRP_LOW;
        end else if (w == smlm_pkg::SMLM_W4) begin
            eff_grp = {g[1], 1'b0};
        end else begin
            eff_grp = g;
        end
    endfunction : eff_grp

    // Drive pattern of the current chunk, top bits of the shifter
    function automatic smlm_pkg::smlm_lanes_t lane_map(
        input logic [7:0] sh,
        input smlm_pkg::smlm_width_t w,
        input logic [1:0] g,
        input logic rx,
        input logic dq
    );
        smlm_pkg::smlm_lanes_t r;
        logic [2:0] b;
        r = '0;
        b = {g, 1'b0};
        case (w)
            // [R2] SI stays driven
            smlm_pkg::SMLM_W1: begin
                r.o[b] = sh[7];
                r.oe[b] = 1'b1;
            end
            // [R3] high bit upper
            smlm_pkg::SMLM_W2: begin
                r.o[3'(b + 3'h1)] = sh[7];
                r.o[b] = sh[6];
                r.oe[3'(b + 3'h1)] = !rx;
                r.oe[b] = !rx;
            end
            smlm_pkg::SMLM_W4: begin
                for (int i = 0; i < 4; i++) begin
                    // [R4] nibble ordering
                    r.o[3'(b + 3'(i))] = sh[4+i];
                    r.oe[3'(b + 3'(i))] = !rx;
                    // [R11] same nibble high
                    if (dq) begin
                        r.o[4+i] = sh[4+i];
                        r.oe[4+i] = !rx;
                    end
                end
            end
            // [R5] [R12] full byte
            default: begin
                r.o = sh;
                r.oe = {8{!rx}};
            end
        endcase
        lane_map = r;
    endfunction : lane_map

    // Shift out one chunk and take in the sampled one
    function automatic logic [7:0] next_sh(
        input logic [7:0] sh,
        input smlm_pkg::smlm_width_t w,
        input logic [1:0] g,
        input logic [7:0] in
    );
        logic [2:0] b;
        b = {g, 1'b0};
        case (w)
            // [R2] SO upper lane
            smlm_pkg::SMLM_W1: next_sh = {sh[6:0], in[3'(b + 3'h1)]};
            smlm_pkg::SMLM_W2: begin
                next_sh = {sh[5:0], in[3'(b + 3'h1)], in[b]};
            end
            smlm_pkg::SMLM_W4: begin
                next_sh = {sh[3:0], in[3'(b + 3'h3)], in[3'(b + 3'h2)],
                    in[3'(b + 3'h1)], in[b]};
            end
            default: next_sh = in;
        endcase
    endfunction : next_sh

    // ************************************************************
    // Next state
    // ************************************************************
    logic [1:0] item_grp;
    logic item_bad;
    logic [3:0] sel_mask;

    always_comb begin
        // [R13] group code and legality
        item_grp = eff_grp(q_item.width,
            dev_grp[2*q_item.dev +: 2], q_item.dq);
        item_bad = (item_grp != dev_grp[2*q_item.dev +: 2]) && !q_item.dq;
        // [R7] one-hot select
        sel_mask = 4'h1 << q_item.dev;
        // [R9] both selects
        if (q_item.dq) begin
            sel_mask = sel_mask | (4'h1 << dq_partner);
            // [R8] [R10] low index at bottom
            item_bad = item_bad || (dq_partner <= q_item.dev)
                || (dev_grp[2*q_item.dev +: 2] != smlm_pkg::GRP_LOW)
                || (dev_grp[2*dq_partner +: 2] != smlm_pkg::GRP_HIGH);
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rx_valid = 1'b0;
        q_pop = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                s_d.busy = 1'b0;
                if (q_valid) begin
                    q_pop = 1'b1;
                    // [R14] fixed select per device
                    s_d.sel_n = ~sel_mask;
                    s_d.dev = q_item.dev;
                    s_d.busy = 1'b1;
                    s_d.st = ST_LOW;
                end
            end
            ST_LOW: begin
                if (s_q.div == HALF_LAST) begin
                    s_d.div = '0;
                    s_d.sck = 1'b1;
                    s_d.st = ST_HIGH;
                end else begin
                    s_d.div = smlm_pkg::CNT_W'(s_q.div + 1'b1);
                end
            end
            ST_HIGH: begin
                if (s_q.div == HALF_LAST) begin
                    // [R15] falling edge launch
                    s_d.div = '0;
                    s_d.sck = 1'b0;
                    // [R1] shift from the top
                    s_d.sh = next_sh(s_q.sh, s_q.width, s_q.grp, lane_s);
                    if (s_q.left != 3'h0) begin
                        s_d.left = 3'(s_q.left - 1'b1);
                        s_d.st = ST_LOW;
                    end else begin
                        s_d.rx_valid = s_q.rx;
                        if (s_q.rx) begin
                            s_d.rx_byte = s_d.sh;
                        end
                        if (s_q.last) begin
                            s_d.sel_n = smlm_pkg::SEL_IDLE;
                            s_d.st = ST_GAP;
                        end else if (q_valid) begin
                            q_pop = 1'b1;
                            s_d.st = ST_LOW;
                        end else begin
                            s_d.st = ST_WAIT;
                        end
                    end
                end else begin
                    s_d.div = smlm_pkg::CNT_W'(s_q.div + 1'b1);
                end
            end
            ST_WAIT: begin
                // Clock parked low with select held; the frame stays open
                if (q_valid) begin
                    q_pop = 1'b1;
                    s_d.st = ST_LOW;
                end
            end
            ST_GAP: begin
                if (s_q.div == GAP_LAST) begin
                    s_d.div = '0;
                    s_d.busy = 1'b0;
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.div = smlm_pkg::CNT_W'(s_q.div + 1'b1);
                end
            end
            default: begin
                s_d = '0;
                s_d.sel_n = smlm_pkg::SEL_IDLE;
            end
        endcase

        if (q_pop) begin
            s_d.sh = q_item.data;
            s_d.width = q_item.width;
            s_d.rx = q_item.rx;
            s_d.last = q_item.last;
            s_d.dq = q_item.dq;
            s_d.grp = item_grp;
            s_d.left = first_left(q_item.width);
            s_d.err = s_q.err || item_bad;
        end

        // [R6] [R16] only the chosen group, released on wide reads
        if (s_d.st == ST_IDLE || s_d.st == ST_GAP) begin
            s_d.lanes = '0;
        end else begin
            s_d.lanes = lane_map(s_d.sh, s_d.width, s_d.grp, s_d.rx,
                s_d.dq);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.sel_n <= smlm_pkg::SEL_IDLE;
            s_q.lanes.o <= smlm_pkg::LANE_RST;
            s_q.lanes.oe <= smlm_pkg::LANE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sck = s_q.sck;
    assign sel_n = s_q.sel_n;
    assign lane_o = s_q.lanes.o;
    assign lane_oe = s_q.lanes.oe;
    assign rx_byte = s_q.rx_byte;
    assign rx_valid = s_q.rx_valid;
    assign busy = s_q.busy;
    assign cfg_err = s_q.err;

endmodule : smlm_top

//--- tb/smlm_top_sva.sv
// Checker of the lane mapper's memory-side pins.
// Assumes it is bound into smlm_top and sees only its ports.
`timescale 1ns/1ns
module smlm_top_sva #(
    parameter int unsigned FIFO_DEPTH = smlm_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Watched outputs
    input wire logic sck,
    input wire logic [3:0] sel_n,
    input wire logic [7:0] lane_o,
    input wire logic [7:0] lane_oe,
    input wire logic rx_valid,
    input wire logic busy,
    input wire logic cfg_err
);
    // ************************************************************
    // Link timing and selects
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    idle_low_a: assert property (&sel_n |-> !sck)
        else $error("serial clock high while unselected");
    launch_fall_a: assert property (sck |-> $stable(lane_o))
        else $error("lane output moved while clock high");
    high_phase_a: assert property
        ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("clock high phase not four cycles");
    low_phase_a: assert property ($fell(sck) |-> (!sck) [*4])
        else $error("clock low phase under four cycles");
    sel_count_a: assert property ($countones(~sel_n) <= 2)
        else $error("more than two selects active");
    rx_on_fall_a: assert property (rx_valid |-> $fell(sck))
        else $error("read byte not on a falling clock");
    idle_release_a: assert property
        (&sel_n |-> lane_oe == 8'h00)
        else $error("lane driven with no select");
    frame_busy_a: assert property (!(&sel_n) |-> busy)
        else $error("select active while not busy");
    cs_gap_a: assert property ($rose(&sel_n) |-> (&sel_n) [*2])
        else $error("select gap shorter than two cycles");
    err_sticky_a: assert property (cfg_err |=> cfg_err)
        else $error("setup error flag dropped");

    rx_seen_c: cover property (rx_valid);
    dual_sel_c: cover property ($countones(~sel_n) == 2);
    err_seen_c: cover property ($rose(cfg_err));
endmodule : smlm_top_sva

bind smlm_top smlm_top_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .sel_n(sel_n),
    .lane_o(lane_o), .lane_oe(lane_oe), .rx_valid(rx_valid),
    .busy(busy), .cfg_err(cfg_err));

//--- tb/smlm_mem_model.sv
// Behavioural serial memory that answers read frames, mode 0.
// Assumes the bench sets lane count, lane base and reply word per frame.
`timescale 1ns/1ns
module smlm_mem_model (
    // Pins
    input wire logic clk_sys,
    input wire logic sck,
    input wire logic [3:0] sel_n,
    input wire logic [7:0] lane_o,
    input wire logic [7:0] lane_oe,
    output logic [7:0] lane_i,
    // Frame setup
    input wire logic [3:0] m_n,
    input wire logic [2:0] m_base,
    input wire logic [31:0] m_word
);
    // ************************************************************
    // Reply shifter and wire resolution
    // ************************************************************
    logic [31:0] sh = 32'h0;
    logic tog = 1'b0;
    logic [7:0] mine;
    logic [7:0] val;
    always @(posedge clk_sys) tog <= ~tog;
    // Top bits first, next on each fall
    always @(negedge (&sel_n)) sh = m_word;
    always @(negedge sck) sh = sh << m_n;
    always_comb begin
        mine = (8'hff >> (4'd8 - m_n)) << m_base;
        val = (sh[31:24] >> (4'd8 - m_n)) << m_base;
        // Lines neither driven nor answered by the memory toggle so a stale value never looks valid
        for (int b = 0; b < 8; b++) begin
            if (lane_oe[b]) lane_i[b] = lane_o[b];
            else if (!(&sel_n) && mine[b]) lane_i[b] = val[b];
            else lane_i[b] = tog ^ b[0];
        end
    end
endmodule : smlm_mem_model

//--- tb/tb_top.sv
// Self-checking bench of the lane mapper against a queue model.
// Assumes one memory model answers reads on the selected group.
`timescale 1ns/1ns
module tb_top;
    // ************************************************************
    // Signals and model state
    // ************************************************************
    logic clk_sys;
    logic rst_n;
    smlm_pkg::smlm_item_t item_data;
    logic item_valid, item_ready, rx_valid, busy, cfg_err, sck;
    logic [7:0] dev_grp, rx_byte, lane_i, lane_o, lane_oe;
    logic [1:0] dq_partner;
    logic [3:0] sel_n, bsel, m_n;
    logic [2:0] m_base;
    logic [31:0] m_word, rng = 32'h3b1d244f;
    int miscompares = 0;
    int num_checks = 0;
    int bw, bb, brx, bdq, acc, nbits, full_seen, w, g;
    logic [7:0] boe;
    logic sck_p = 1'b0;
    int exp_q[$];

    smlm_top #(.FIFO_DEPTH(8)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .item_data(item_data), .item_valid(item_valid),
        .item_ready(item_ready), .dev_grp(dev_grp),
        .dq_partner(dq_partner), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .busy(busy), .cfg_err(cfg_err), .sck(sck), .sel_n(sel_n),
        .lane_i(lane_i), .lane_o(lane_o), .lane_oe(lane_oe));
    smlm_mem_model u_mem (.clk_sys(clk_sys), .sck(sck), .sel_n(sel_n),
        .lane_o(lane_o), .lane_oe(lane_oe), .lane_i(lane_i), .m_n(m_n),
        .m_base(m_base), .m_word(m_word));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    function automatic logic [31:0] xs;
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic timeout;
        miscompares++;
        $display("[FAIL] t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
        wrap_up();
    endtask : timeout

    // Send one frame of nb bytes and wait until the link is idle again
    task automatic run_frame(input int w, input int g, input int d,
                             input int dq, input int rx, input int nb);
        int k;
        int t;
        logic [7:0] b;
        bw = 1 << w;
        bb = (w < 2) ? 2 * g : (w == 2) ? 4 * (g / 2) : 0;
        brx = rx;
        bdq = dq;
        nbits = 0;
        acc = 0;
        bsel = ~(4'h1 << d);
        if (dq != 0) bsel &= ~(4'h1 << dq_partner);
        boe = (w == 0) ? 8'h1 << bb : (rx != 0) ? 8'h00 :
              (dq != 0) ? 8'hff : (8'hff >> (8 - bw)) << bb;
        m_n = bw;
        m_base = (w == 0) ? bb + 1 : bb;
        m_word = xs();
        for (k = 0; k < nb; k++) begin
            b = (rx != 0) ? m_word[31 - 8 * k -: 8] : xs();
            exp_q.push_back(b);
            item_data = {d[1:0], dq[0], rx[0], w[1:0], k == nb - 1, b};
            item_valid = 1'b1;
            for (t = 0; item_ready !== 1'b1; t++) begin
                if (t > 2000) timeout();
                @(posedge clk_sys) #1;
            end
            @(posedge clk_sys) #1;
        end
        item_valid = 1'b0;
        repeat (3) @(posedge clk_sys) #1;
        for (t = 0; busy !== 1'b0; t++) begin
            if (t > 5000) timeout();
            @(posedge clk_sys) #1;
        end
        check(exp_q.size(), 0);
        $display("frame w=%0d g=%0d rx=%0d done", w, g, rx);
    endtask : run_frame

    // ************************************************************
    // Monitor: wire bytes and read bytes against the queue
    // ************************************************************
    always @(posedge clk_sys) begin
        sck_p <= sck;
        // Only back-pressure from a full FIFO counts, not the reset hold-off
        if (item_valid && !item_ready && busy) full_seen = 1;
        if (rx_valid) check(rx_byte, exp_q.pop_front());
        if (sck && !sck_p) begin
            check(sel_n, bsel);
            check(lane_oe, boe);
            if (brx == 0) begin
                acc = (acc << bw) | ((lane_o >> bb) & ((1 << bw) - 1));
                if (bdq != 0 && bw == 4) begin
                    check(lane_o[7:4], lane_o[3:0]);
                end
                nbits += bw;
                if (nbits == 8) begin
                    check(acc & 8'hff, exp_q.pop_front());
                    nbits = 0;
                end
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        item_valid = 1'b0;
        item_data = '0;
        dev_grp = 8'h00;
        dq_partner = 2'h1;
        full_seen = 0;
        repeat (16) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        for (w = 0; w < 4; w++) begin
            for (g = 0; g < 4; g++) begin
                if ((w == 2 && g % 2 == 1) || (w == 3 && g > 0)) continue;
                dev_grp = {4{g[1:0]}};
                run_frame(w, g, xs() % 4, 0, 0, (g == 0) ? 10 : 2);
                run_frame(w, g, xs() % 4, 0, 1, 2);
            end
        end
        check(full_seen, 1);
        dev_grp = 8'h08;
        run_frame(2, 0, 0, 1, 0, 2);
        run_frame(3, 0, 0, 1, 0, 2);
        run_frame(3, 0, 0, 1, 1, 2);
        check(cfg_err, 0);
        dev_grp = 8'h55;
        run_frame(2, 1, xs() % 4, 0, 0, 2);
        check(cfg_err, 1);
        wrap_up();
    end
endmodule : tb_top
